// File: core/sttcc_consts.vh
`ifndef STTCC_CONSTS_VH
`define STTCC_CONSTS_VH
`define STTCC_A_FORCE 8'h31
`define STTCC_A_CTL3 8'h80
`define STTCC_A_CTL4 8'h81
`define STTCC_A_CNT_HI 8'h82
`define STTCC_A_CNT_LO 8'h83
`define STTCC_A_OC1_HI 8'h84
`define STTCC_A_OC2_HI 8'h86
`define STTCC_A_OC3_HI 8'h88
`define STTCC_A_C4_HI 8'h8A
`define STTCC_A_C4_LO 8'h8B
`define STTCC_A_MSK 8'h8C
`define STTCC_A_FLG 8'h8D
`define STTCC_RST_CMP 16'hFFFF
`define STTCC_RST_CNT 16'h0000
`define STTCC_PRESET_CNT 16'hFFF8
`define STTCC_RST_BYTE 8'h00
`define STTCC_C4_FN 0
`define STTCC_STOP 1
`define STTCC_ECE_LSB 2
`define STTCC_PR_LSB 4
`define STTCC_EDG_LSB 6
`define STTCC_FLG_OVF 3
`define STTCC_ACT_TOG 2'h1
`define STTCC_ACT_LOW 2'h2
`define STTCC_ACT_HIGH 2'h3
`endif

// File: core/sttcc_timer.v
// Function
// [RQ1] Four-stage prescaler feeds sixteen-bit up-counter.
// [RQ2] Internal clock divides by 1, 4, 8, 16.
// [RQ3] Event mode counts external input edges.
// [RQ4] Switching to event mode keeps counter value.
// [RQ5] Compare match each tick sets channel flag.
// [RQ6] Channels one to three share one request.
// [RQ7] Match applies programmed pin action.
// [RQ8] Action codes: off, toggle, low, high.
// [RQ9] Function bit picks capture or compare.
// [RQ10] Capture copies counter on selected edge.
// [RQ11] Capture edge: off, rise, fall, any.
// [RQ12] Event edge: internal, rise, fall, both.
// [RQ13] Prescale and event bits write once.
// [RQ14] Force bits: high third timer, low this.
// [RQ15] Force does pin action without flag.
// [RQ16] Forced action at next count transition.
// [RQ17] Software avoids forcing toggle channels.
// [RQ18] Compare registers reset FFFF, plain storage.
// [RQ19] High byte write blocks compare one cycle.
// [RQ20] Channel-four register resets to ones.
// [RQ21] Counter write clears; reset value zero.
// [RQ22] Special mode high write presets FFF8.
// [RQ23] Stop bit halts and zeroes counter.
// [RQ24] High byte read latches low byte.
// [RQ25] Wrap sets overflow flag, masked request.
//
// Our own choice: the strobed register port.
`include "sttcc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module sttcc_timer (
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [7:0] wrData,
	input wire wrStb,
	input wire rdStb,
	output reg [7:0] rdData,
	input wire specialModeFlag,
	input wire externalCountInput,
	input wire channelFourPinIn,
	output wire channelFourPinOut,
	output wire channelFourPinOeN,
	output wire compareOutOne,
	output wire compareOutTwo,
	output wire compareOutThree,
	output wire [3:0] forceThirdTimer,
	output wire forceThirdTimerStb,
	output wire compareIrq,
	output wire channelFourIrq,
	output wire overflowIrq
);
	// ==========================================================
	// Helpers
	function [1:0] actCode;
		input [7:0] ctl;
		input [1:0] ch;
		begin
			actCode = ctl[7 - 2 * ch -: 2];
		end
	endfunction

	function pinNext;
		input [1:0] act;
		input cur;
		begin
			case (act)
				`STTCC_ACT_TOG: pinNext = ~cur;
				`STTCC_ACT_LOW: pinNext = 1'b0;
				`STTCC_ACT_HIGH: pinNext = 1'b1;
				default: pinNext = cur;
			endcase
		end
	endfunction

	function edgeHit;
		input [1:0] sel;
		input cur;
		input prev;
		begin
			edgeHit = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
		end
	endfunction

	// ==========================================================
	// Registers
	reg [15:0] cnt_q;
	reg [15:0] cmp_q [0:3];
	reg [7:0] ctl3_q;
	reg [7:0] ctl4_q;
	reg [7:0] msk_q;
	reg [4:0] flg_q;
	reg [3:0] force_q;
	reg [3:0] third_q;
	reg thirdStb_q;
	reg onceDone_q;
	reg [3:0] hiWr_q;
	reg [3:0] pre_q;
	reg [7:0] loLatch_q;
	reg [3:0] pin_q;
	reg [2:0] ecSync_q;
	reg [2:0] c4Sync_q;
	reg ecStable_q;
	reg c4Stable_q;
	reg [2:0] warm_q;
	integer matchIdx;
	integer pinIdx;
	integer flagIdx;
	integer regIdx;

	wire [1:0] prSel = ctl4_q[`STTCC_PR_LSB +: 2];
	wire [1:0] eceSel = ctl4_q[`STTCC_ECE_LSB +: 2];
	wire [1:0] edgSel = ctl4_q[`STTCC_EDG_LSB +: 2];
	wire stop = ctl4_q[`STTCC_STOP];
	wire c4Capture = ctl4_q[`STTCC_C4_FN];

	// Inputs pass three flops; a level counts once stages two and three agree.
	wire ecAgree = (ecSync_q[1] == ecSync_q[2]);
	wire c4Agree = (c4Sync_q[1] == c4Sync_q[2]);
	wire ecNew = ecAgree ? ecSync_q[2] : ecStable_q;
	wire c4New = c4Agree ? c4Sync_q[2] : c4Stable_q;
	// The pipe resets low while an idle pin may sit high, so edges are
	// ignored until it has filled; otherwise reset would fake an edge.
	wire warm = warm_q[2];

	// ==========================================================
	// Timer tick
	reg preTick;
	always @* begin
		case (prSel) // [RQ2]
			2'h0: preTick = 1'b1;
			2'h1: preTick = (pre_q[1:0] == 2'h3);
			2'h2: preTick = (pre_q[2:0] == 3'h7);
			default: preTick = (pre_q == 4'hF);
		endcase
	end
	wire evTick = warm & edgeHit(eceSel, ecNew, ecStable_q); // [RQ3] [RQ12]
	wire tick = ~stop & ((eceSel == 2'h0) ? preTick : evTick);
	wire cntWr = wrStb & ((addr == `STTCC_A_CNT_HI) |
		(addr == `STTCC_A_CNT_LO));
	wire capHit = warm & c4Capture &
		edgeHit(edgSel, c4New, c4Stable_q); // [RQ11]

	reg [3:0] match;
	always @* begin
		for (matchIdx = 0; matchIdx < 4; matchIdx = matchIdx + 1) begin
			match[matchIdx] = tick & ~hiWr_q[matchIdx] &
				(cmp_q[matchIdx] == cnt_q); // [RQ5] [RQ19]
		end
		match[3] = match[3] & ~c4Capture; // [RQ9]
	end

	// ==========================================================
	// Input synchronisers
	always @(posedge clk) begin
		if (rst) begin
			ecSync_q <= 3'h0;
			c4Sync_q <= 3'h0;
			ecStable_q <= 1'b0;
			c4Stable_q <= 1'b0;
			warm_q <= 3'h0;
		end else begin
			ecSync_q <= {ecSync_q[1:0], externalCountInput};
			c4Sync_q <= {c4Sync_q[1:0], channelFourPinIn};
			ecStable_q <= ecNew;
			c4Stable_q <= c4New;
			if (!warm) begin
				warm_q <= warm_q + 3'h1;
			end
		end
	end

	// ==========================================================
	// Prescaler and counter
	always @(posedge clk) begin
		if (rst) begin
			pre_q <= 4'h0;
			cnt_q <= `STTCC_RST_CNT; // [RQ21]
		end else begin
			// Prescaler stages run and are held clear while stopped.
			pre_q <= stop ? 4'h0 : pre_q + 4'h1; // [RQ1] [RQ23]
			// Event mode keeps the count; only stop or a write zeroes it.
			if (stop) begin
				cnt_q <= `STTCC_RST_CNT; // [RQ23]
			end else if (tick) begin
				cnt_q <= cnt_q + 16'h0001; // [RQ1] [RQ4]
			end
			if (cntWr) begin
				if (specialModeFlag) begin
					if (addr == `STTCC_A_CNT_HI) begin
						cnt_q <= `STTCC_PRESET_CNT; // [RQ22]
					end
				end else begin
					cnt_q <= `STTCC_RST_CNT; // [RQ21]
				end
			end
		end
	end

	// ==========================================================
	// Pin actions and force
	always @(posedge clk) begin
		if (rst) begin
			pin_q <= 4'h0;
			force_q <= 4'h0;
			third_q <= 4'h0;
			thirdStb_q <= 1'b0;
		end else begin
			thirdStb_q <= 1'b0;
			// Force bit three is channel one; a force never sets a flag.
			for (pinIdx = 0; pinIdx < 4; pinIdx = pinIdx + 1) begin
				if (tick & (match[pinIdx] | force_q[3 - pinIdx])) begin
					pin_q[pinIdx] <= pinNext(actCode(ctl3_q,
						pinIdx[1:0]), pin_q[pinIdx]); // [RQ7] [RQ8] [RQ15]
				end
			end
			// Bits applied on this tick are dropped, so a force written
			// on a tick fires once, at the next one.
			if (wrStb & (addr == `STTCC_A_FORCE)) begin
				force_q <= (tick ? 4'h0 : force_q) |
					wrData[3:0]; // [RQ14] [RQ16]
				third_q <= wrData[7:4]; // [RQ14]
				thirdStb_q <= 1'b1;
			end else if (tick) begin
				force_q <= 4'h0; // [RQ16]
			end
		end
	end

	// ==========================================================
	// Flags
	always @(posedge clk) begin
		if (rst) begin
			flg_q <= 5'h00;
		end else begin
			// Hardware set beats a software clear in the same cycle.
			if (wrStb & (addr == `STTCC_A_FLG)) begin
				flg_q <= flg_q & ~wrData[7:3];
			end
			for (flagIdx = 0; flagIdx < 4; flagIdx = flagIdx + 1) begin
				if (match[flagIdx]) begin
					flg_q[4 - flagIdx] <= 1'b1; // [RQ5]
				end
			end
			if (capHit) begin
				flg_q[1] <= 1'b1;
			end
			if (tick & (cnt_q == 16'hFFFF)) begin
				flg_q[0] <= 1'b1; // [RQ25]
			end
		end
	end

	// ==========================================================
	// Register writes
	always @(posedge clk) begin
		if (rst) begin
			for (regIdx = 0; regIdx < 4; regIdx = regIdx + 1) begin
				cmp_q[regIdx] <= `STTCC_RST_CMP; // [RQ18] [RQ20]
			end
			ctl3_q <= `STTCC_RST_BYTE;
			ctl4_q <= `STTCC_RST_BYTE;
			msk_q <= `STTCC_RST_BYTE;
			onceDone_q <= 1'b0;
			hiWr_q <= 4'h0;
		end else begin
			hiWr_q <= 4'h0;
			// A software write in the same cycle wins over a capture.
			if (capHit) begin
				cmp_q[3] <= cnt_q; // [RQ10]
			end
			if (wrStb) begin
				case (addr)
					`STTCC_A_CTL3: ctl3_q <= wrData;
					`STTCC_A_CTL4: begin
						ctl4_q[`STTCC_EDG_LSB +: 2] <= wrData[7:6];
						ctl4_q[1:0] <= wrData[1:0];
						if (!onceDone_q) begin
							ctl4_q[5:2] <= wrData[5:2]; // [RQ13]
							onceDone_q <= 1'b1; // [RQ13]
						end
					end
					`STTCC_A_MSK: msk_q <= {wrData[7:3], 3'h0};
					default: begin
						if (addr >= `STTCC_A_OC1_HI &&
							addr <= `STTCC_A_C4_LO) begin
							if (addr[0]) begin
								cmp_q[addr[2:1] - 2'h2][7:0] <= wrData;
							end else begin
								cmp_q[addr[2:1] - 2'h2][15:8] <= wrData;
								hiWr_q[addr[2:1] - 2'h2] <= 1'b1; // [RQ19]
							end
						end
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Read port
	always @(posedge clk) begin
		if (rst) begin
			loLatch_q <= 8'h00;
			rdData <= 8'h00;
		end else if (rdStb) begin
			if (addr == `STTCC_A_CNT_HI) begin
				loLatch_q <= cnt_q[7:0]; // [RQ24]
			end
			case (addr)
				`STTCC_A_FORCE: rdData <= {third_q, force_q};
				`STTCC_A_CTL3: rdData <= ctl3_q;
				`STTCC_A_CTL4: rdData <= ctl4_q;
				`STTCC_A_CNT_HI: rdData <= cnt_q[15:8];
				`STTCC_A_CNT_LO: rdData <= loLatch_q; // [RQ24]
				`STTCC_A_MSK: rdData <= msk_q;
				`STTCC_A_FLG: rdData <= {flg_q, 3'h0};
				default: begin
					if (addr >= `STTCC_A_OC1_HI &&
						addr <= `STTCC_A_C4_LO) begin
						rdData <= addr[0] ?
							cmp_q[addr[2:1] - 2'h2][7:0] :
							cmp_q[addr[2:1] - 2'h2][15:8];
					end else begin
						rdData <= 8'h00;
					end
				end
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end

	// ==========================================================
	// Outputs
	assign compareOutOne = pin_q[0];
	assign compareOutTwo = pin_q[1];
	assign compareOutThree = pin_q[2];
	assign channelFourPinOut = pin_q[3];
	// Capture mode or a disconnected action leaves the pin to the port.
	assign channelFourPinOeN = c4Capture | (ctl3_q[1:0] == 2'h0);
	assign forceThirdTimer = third_q;
	assign forceThirdTimerStb = thirdStb_q;
	assign compareIrq = |(flg_q[4:2] & msk_q[7:5]); // [RQ6]
	assign channelFourIrq = flg_q[1] & msk_q[4];
	assign overflowIrq = flg_q[0] & msk_q[`STTCC_FLG_OVF]; // [RQ25]
endmodule
`default_nettype wire

// File: bench/sttcc_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Far side: count source and the channel-four line, pulled up when idle.
module sttcc_pins (
	input wire logic clk,
	input wire logic pinOut,
	input wire logic pinOeN,
	input wire logic capLvl,
	output logic countIn,
	output logic capIn
);
	initial countIn = 1'b0;
	assign capIn = pinOeN ? capLvl : pinOut;
	// Five-cycle halves keep both-edge counting below a quarter of clk.
	task pulse(input int n);
		repeat (n) begin
			repeat (5) @(posedge clk);
			countIn <= 1'b1;
			repeat (5) @(posedge clk);
			countIn <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// File: bench/sttcc_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Read figures assume the bench leaves one idle cycle after a write.
module sttcc_timer_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] rdData,
	input wire logic specialModeFlag,
	input wire logic [3:0] forceThirdTimer,
	input wire logic forceThirdTimerStb,
	input wire logic compareIrq,
	input wire logic overflowIrq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_wr(logic [7:0] a);
		wrStb && addr == a;
	endsequence
	sequence s_hiRead;
		rdStb && addr == 8'h82;
	endsequence
	a_rd_idle: assert property (!$past(rdStb) |-> rdData == 8'h00)
		else $error("read data not idle");
	a_cnt_clear: assert property (s_wr(8'h82) ##0 !specialModeFlag
		##2 s_hiRead |=> rdData == 8'h00) else $error("count not cleared");
	a_cnt_preset: assert property (s_wr(8'h82) ##0 specialModeFlag
		##2 s_hiRead |=> rdData == 8'hFF) else $error("count not preset");
	a_stop_zero: assert property (s_wr(8'h81) ##0 wrData[1]
		##2 s_hiRead |=> rdData == 8'h00) else $error("stop not zero");
	a_force_bits: assert property (s_wr(8'h31) |=>
		{forceThirdTimer, 4'h0} == ($past(wrData) & 8'hF0))
		else $error("third timer force bits wrong");
	a_force_stb: assert property (s_wr(8'h31)
		|-> ##[1:2] forceThirdTimerStb) else $error("no force strobe");
	a_cmp_mask: assert property (s_wr(8'h8C) ##0 wrData[7:5] == 3'h0
		|=> !compareIrq) else $error("masked compare request");
	a_ovf_mask: assert property (wrStb && addr == 8'h8C && !wrData[3]
		|=> !overflowIrq) else $error("masked overflow request");
endmodule
bind sttcc_timer sttcc_timer_sva C (.clk, .rst, .addr, .wrData, .wrStb,
	.rdStb, .rdData, .specialModeFlag, .forceThirdTimer, .forceThirdTimerStb,
	.compareIrq, .overflowIrq);
`default_nettype wire

// File: bench/test_second_timer_capture_compare.sv
`timescale 1ns/1ps
`default_nettype none
module test_second_timer_capture_compare;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wrData = 8'h00;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic specialModeFlag = 1'b0;
	logic capLvl = 1'b1;
	logic [7:0] rdData, q;
	logic [3:0] forceThirdTimer;
	logic externalCountInput, channelFourPinIn, channelFourPinOut;
	logic channelFourPinOeN, compareOutOne, compareOutTwo, compareOutThree;
	logic forceThirdTimerStb, compareIrq, channelFourIrq, overflowIrq;
	logic [7:0] mdl [6];
	int expDelta [7] = '{64, 16, 8, 4, 8, 8, 16};
	int numErrors = 0;
	int nCompared = 0;
	int seed = 32'hE654;
	int k, d, v0, v1;
	always #10 clk = ~clk;
	sttcc_timer DUT (.clk, .rst, .addr, .wrData, .wrStb, .rdStb, .rdData,
		.specialModeFlag, .externalCountInput, .channelFourPinIn,
		.channelFourPinOut, .channelFourPinOeN, .compareOutOne,
		.compareOutTwo, .compareOutThree, .forceThirdTimer,
		.forceThirdTimerStb, .compareIrq, .channelFourIrq, .overflowIrq);
	sttcc_pins P (.clk, .pinOut(channelFourPinOut), .pinOeN(channelFourPinOeN),
		.capLvl, .countIn(externalCountInput), .capIn(channelFourPinIn));
	// ==========
	// Bus tasks; each leaves one idle cycle so strobes never collide.
	task chk(input logic [15:0] got, input logic [15:0] exp);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] dt);
		addr <= a;
		wrData <= dt;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		@(posedge clk);
		q = rdData;
	endtask
	task rx(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(q, e);
	endtask
	task cnt(output int v);
		rd(8'h82);
		v = {q, 8'h00};
		rd(8'h83);
		v = v | q;
	endtask
	task doReset;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask
	task results;
		$display("compared %0d errors %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========
	// Scenarios.
	initial begin
		for (k = 0; k < 7; k++) begin
			doReset();
			wr(8'h81, k < 4 ? 8'(k << 4) : 8'((k - 3) << 2));
			wr(8'h81, 8'h3C);
			cnt(v0);
			if (k < 4) repeat (60) @(posedge clk);
			else P.pulse(8);
			if (k > 3) repeat (8) @(posedge clk);
			cnt(v1);
			chk(16'(v1 - v0), 16'(expDelta[k]));
		end
		doReset();
		for (k = 8'h84; k < 8'h8C; k++) rx(8'(k), 8'hFF);
		rx(8'h00, 8'h00);
		for (k = 0; k < 6; k++) begin
			mdl[k] = 8'($random(seed));
			wr(8'h84 + 8'(k), mdl[k]);
		end
		for (k = 0; k < 6; k++) rx(8'h84 + 8'(k), mdl[k]);
		wr(8'h82, 8'h00);
		rx(8'h82, 8'h00);
		specialModeFlag <= 1'b1;
		wr(8'h82, 8'h00);
		rx(8'h82, 8'hFF);
		wr(8'h8C, 8'h08);
		repeat (10) @(posedge clk);
		chk(overflowIrq, 1'b1);
		specialModeFlag <= 1'b0;
		wr(8'h8D, 8'hFF);
		wr(8'h8C, 8'h00);
		wr(8'h80, 8'hFC);
		wr(8'h31, 8'h0E);
		repeat (3) @(posedge clk);
		chk({compareOutOne, compareOutTwo, compareOutThree}, 3'h7);
		rx(8'h8D, 8'h00);
		cnt(v0);
		wr(8'h80, 8'h90);
		for (k = 0; k < 4; k++)
			wr(8'h84 + 8'(k), 8'((v0 + 40) >> (k[0] ? 0 : 8)));
		wr(8'h8C, 8'hE0);
		for (d = 0; d < 99 && compareOutOne !== 1'b0; d++) @(posedge clk);
		if (d == 99) begin
			numErrors++;
			results();
		end
		repeat (2) @(posedge clk);
		chk({compareOutOne, compareOutTwo, compareOutThree}, 3'h1);
		chk(compareIrq, 1'b1);
		rd(8'h8D);
		chk(q & 8'hC0, 8'hC0);
		for (k = 0; k < 4; k++) begin
			wr(8'h81, 8'(k << 6) | 8'h03);
			rx(8'h82, 8'h00);
			chk(channelFourPinOeN, 1'b1);
			wr(8'h8A, 8'hFF);
			capLvl <= 1'b0;
			repeat (8) @(posedge clk);
			rx(8'h8A, k[1] ? 8'h00 : 8'hFF);
			wr(8'h8A, 8'hFF);
			capLvl <= 1'b1;
			repeat (8) @(posedge clk);
			rx(8'h8A, k[0] ? 8'h00 : 8'hFF);
		end
		rd(8'h8D);
		chk(q & 8'h10, 8'h10);
		results();
	end
endmodule
`default_nettype wire
